// >>> include/timer_set_regs.vh
`ifndef TIMER_SET_REGS_VH
`define TIMER_SET_REGS_VH

// ****************************************
// register map
// ****************************************
// each timer owns a 32-byte slot: index = addr[7:5]
`define TMR_SLOT_LSB      5
`define TMR_SLOT_MSB      7
`define TMR_NUM           5
// word select inside a slot: addr[4:2]
`define TMR_CON_SEL       3'h0
`define TMR_CNT_SEL       3'h1
`define TMR_PER_SEL       3'h2
// slot 5 word 0 holds the match flags
`define TMR_STATUS_SLOT   3'h5
`define TMR_STATUS_ADDR   8'hA0

// ****************************************
// control field layout
// ****************************************
`define CON_SRC_BIT       1
`define CON_SYNC_BIT      2
`define CON_PAIR_BIT      3
`define CON_PRE_LSB       4
`define CON_PRE_MSB       5
`define CON_GATE_BIT      6
`define CON_ON_BIT        15
`define CON_WRITE_MASK    16'h807E

// ****************************************
// reset values
// ****************************************
`define CON_RESET         16'h0000
`define CNT_RESET         16'h0000
`define PER_RESET         16'hFFFF
`define FLAGS_RESET       5'h00

// ****************************************
// prescaler terminal counts (1, 8, 64, 256)
// ****************************************
`define PRE_LAST_1        8'h00
`define PRE_LAST_8        8'h07
`define PRE_LAST_64       8'h3F
`define PRE_LAST_256      8'hFF

// ****************************************
// bus answers
// ****************************************
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// >>> hdl/timer_set.v
`timescale 1ns/1ns
`include "timer_set_regs.vh"

module timer_set (
    // clock and reset
    input  wire        mclk,
    input  wire        rst,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // external count clocks and gates, one per timer (0 = standalone)
    input  wire [4:0]  extCountClockPin,
    input  wire [4:0]  gatePin,
    // time base toward capture and compare units
    output reg  [15:0] timeBaseLow,
    output reg  [15:0] timeBaseHigh,
    // event outputs
    output reg         converterTrigger,
    output reg  [3:0]  dmaRequest,
    output reg  [4:0]  matchFlags
);

    // ****************************************
    // storage
    // ****************************************
    reg  [15:0] con_reg [0:4];
    reg  [15:0] cnt_reg [0:4];
    reg  [15:0] per_reg [0:4];
    reg  [7:0]  pre_reg [0:4];
    reg  [15:0] cnt_next [0:4];
    reg  [7:0]  pre_next [0:4];
    reg  [4:0]  extMeta_reg;
    reg  [4:0]  extSync_reg;
    reg  [4:0]  extPrev_reg;
    reg  [4:0]  gateMeta_reg;
    reg  [4:0]  gateSync_reg;
    reg  [4:0]  syncStage_reg;
    reg  [4:0]  rawEvent;
    reg  [4:0]  preTick;
    reg  [4:0]  tick;
    reg  [4:0]  matchNow;
    reg  [31:0] count32;
    reg  [31:0] period32;
    reg  [7:0]  awAddr_reg;
    reg  [31:0] wData_reg;
    reg  [3:0]  wStrb_reg;
    reg         awHeld_reg;
    reg         wHeld_reg;
    wire [2:0]  wSlot;
    wire [2:0]  wSel;
    wire [2:0]  rSlot;
    wire [2:0]  rSel;
    wire        doWrite;
    wire [4:0]  flagClear;
    integer     i;
    integer     j;
    integer     k;
    integer     p;

    // ****************************************
    // helpers
    // ****************************************
    // terminal count of the prescaler for a ratio field
    function [7:0] preLast;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    preLast = `PRE_LAST_1;
                2'h1:    preLast = `PRE_LAST_8;
                2'h2:    preLast = `PRE_LAST_64;
                default: preLast = `PRE_LAST_256;
            endcase
        end
    endfunction

    // merge the low two byte lanes into a 16-bit register
    function [15:0] laneMerge;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            laneMerge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    // true when a low timer pairs up with its high neighbour
    function pairOn;
        input [15:0] lowCon;
        begin
            pairOn = lowCon[`CON_PAIR_BIT];
        end
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    // two stages on every pin; prev stage only for edge detect
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            extMeta_reg  <= 5'h00;
            extSync_reg  <= 5'h00;
            extPrev_reg  <= 5'h00;
            gateMeta_reg <= 5'h00;
            gateSync_reg <= 5'h00;
        end else begin
            extMeta_reg  <= extCountClockPin;
            extSync_reg  <= extMeta_reg;
            extPrev_reg  <= extSync_reg;
            gateMeta_reg <= gatePin;
            gateSync_reg <= gateMeta_reg;
        end
    end

    // ****************************************
    // count events and prescalers
    // ****************************************
    // raw event per timer, then prescaled tick, then optional sync stage
    always @* begin
        for (i = 0; i < `TMR_NUM; i = i + 1) begin
            pre_next[i] = pre_reg[i];
            rawEvent[i] = 1'b0;
            if (con_reg[i][`CON_ON_BIT]) begin
                if (con_reg[i][`CON_SRC_BIT])
                    rawEvent[i] = extSync_reg[i] & ~extPrev_reg[i];
                else if (con_reg[i][`CON_GATE_BIT])
                    rawEvent[i] = gateSync_reg[i];
                else
                    rawEvent[i] = 1'b1;
            end
            preTick[i] = rawEvent[i] && (pre_reg[i] == preLast(con_reg[i][`CON_PRE_MSB:`CON_PRE_LSB]));
            if (rawEvent[i])
                pre_next[i] = preTick[i] ? 8'h00 : pre_reg[i] + 8'h01;
            // sync only for counter mode; paired timers always synchronous
            if (con_reg[i][`CON_SRC_BIT] && (con_reg[i][`CON_SYNC_BIT] || i != 0))
                tick[i] = syncStage_reg[i];
            else
                tick[i] = preTick[i];
        end
    end

    // ****************************************
    // counters and period match
    // ****************************************
    // 16-bit counting per timer, pairs override when joined
    always @* begin
        matchNow = 5'h00;
        count32  = 32'h0000_0000;
        period32 = 32'h0000_0000;
        for (j = 0; j < `TMR_NUM; j = j + 1) begin
            cnt_next[j] = cnt_reg[j];
            if (tick[j]) begin
                if (cnt_reg[j] == per_reg[j]) begin
                    cnt_next[j] = 16'h0000;
                    matchNow[j] = 1'b1;
                end else begin
                    cnt_next[j] = cnt_reg[j] + 16'h0001;
                end
            end
        end
        for (p = 1; p < `TMR_NUM; p = p + 2) begin
            if (pairOn(con_reg[p])) begin
                matchNow[p]   = 1'b0;
                matchNow[p+1] = 1'b0;
                cnt_next[p+1] = cnt_reg[p+1];
                count32  = {cnt_reg[p+1], cnt_reg[p]};
                period32 = {per_reg[p+1], per_reg[p]};
                if (tick[p]) begin
                    if (count32 == period32) begin
                        cnt_next[p]   = 16'h0000;
                        cnt_next[p+1] = 16'h0000;
                        matchNow[p+1] = 1'b1;
                    end else begin
                        {cnt_next[p+1], cnt_next[p]} = count32 + 32'h0000_0001;
                    end
                end
            end
        end
    end

    // ****************************************
    // bus decode
    // ****************************************
    assign wSlot     = awAddr_reg[`TMR_SLOT_MSB:`TMR_SLOT_LSB];
    assign wSel      = awAddr_reg[4:2];
    assign rSlot     = s_axi_araddr[`TMR_SLOT_MSB:`TMR_SLOT_LSB];
    assign rSel      = s_axi_araddr[4:2];
    assign doWrite   = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign flagClear = (doWrite && awAddr_reg == `TMR_STATUS_ADDR && wStrb_reg[0]) ? wData_reg[4:0] : 5'h00;

    // ****************************************
    // timer state and register writes
    // ****************************************
    // bus write wins over the counter for the same register
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (k = 0; k < `TMR_NUM; k = k + 1) begin
                con_reg[k] <= `CON_RESET;
                cnt_reg[k] <= `CNT_RESET;
                per_reg[k] <= `PER_RESET;
                pre_reg[k] <= 8'h00;
            end
            syncStage_reg <= 5'h00;
            matchFlags    <= `FLAGS_RESET;
        end else begin
            syncStage_reg <= preTick;
            matchFlags    <= (matchFlags & ~flagClear) | matchNow;
            for (k = 0; k < `TMR_NUM; k = k + 1) begin
                cnt_reg[k] <= cnt_next[k];
                pre_reg[k] <= pre_next[k];
                if (doWrite && wSlot == k) begin
                    if (wSel == `TMR_CON_SEL)
                        con_reg[k] <= laneMerge(con_reg[k], wData_reg, wStrb_reg) & `CON_WRITE_MASK;
                    if (wSel == `TMR_CNT_SEL)
                        cnt_reg[k] <= laneMerge(cnt_reg[k], wData_reg, wStrb_reg);
                    if (wSel == `TMR_PER_SEL)
                        per_reg[k] <= laneMerge(per_reg[k], wData_reg, wStrb_reg);
                end
            end
        end
    end

    // ****************************************
    // event outputs
    // ****************************************
    // registered pulses and time base copies
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            converterTrigger <= 1'b0;
            dmaRequest       <= 4'h0;
            timeBaseLow      <= 16'h0000;
            timeBaseHigh     <= 16'h0000;
        end else begin
            converterTrigger <= matchNow[2] | matchNow[4];
            dmaRequest       <= matchNow[4:1];
            timeBaseLow      <= cnt_next[1];
            timeBaseHigh     <= cnt_next[2];
        end
    end

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    // address and data taken in either order, response after both
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 32'h0000_0000;
            wStrb_reg     <= 4'h0;
        end else begin
            s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_reg   <= 1'b0;
                wHeld_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if ((wSlot < `TMR_NUM && wSel <= `TMR_PER_SEL) || awAddr_reg == `TMR_STATUS_ADDR)
                    s_axi_bresp <= `RESP_OKAY;
                else
                    s_axi_bresp <= `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    // one read at a time, data one cycle after the address
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                if (s_axi_araddr == `TMR_STATUS_ADDR)
                    s_axi_rdata <= {27'h0000000, matchFlags};
                else if (rSlot < `TMR_NUM && rSel == `TMR_CON_SEL)
                    s_axi_rdata <= {16'h0000, con_reg[rSlot]};
                else if (rSlot < `TMR_NUM && rSel == `TMR_CNT_SEL)
                    s_axi_rdata <= {16'h0000, cnt_reg[rSlot]};
                else if (rSlot < `TMR_NUM && rSel == `TMR_PER_SEL)
                    s_axi_rdata <= {16'h0000, per_reg[rSlot]};
                else
                    s_axi_rresp <= `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // timer_set

// >>> tb/timer_set_assertions.sv
`timescale 1ns/1ns
// ****************************************
// port checker for the timer set
// ****************************************
module timer_set_assertions (
    // clock and reset
    input wire        mclk,
    input wire        rst,
    // bus handshakes
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // timer events
    input wire [15:0] timeBaseLow,
    input wire        converterTrigger,
    input wire [3:0]  dmaRequest,
    input wire [4:0]  matchFlags
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_writeAnswer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_writeAnswer: assert property (p_writeAnswer) else $error("write got no response");
    property p_readAnswer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_readAnswer: assert property (p_readAnswer) else $error("read got no data");
    property p_readDone;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_readDone: assert property (p_readDone) else $error("read data repeated");
    property p_dmaPulse;
        $rose(matchFlags[1]) |-> dmaRequest[0];
    endproperty
    a_dmaPulse: assert property (p_dmaPulse) else $error("match without dma request");
    property p_pairEvent;
        $rose(matchFlags[2]) |-> dmaRequest[1] && converterTrigger;
    endproperty
    a_pairEvent: assert property (p_pairEvent) else $error("pair match without trigger");
    property p_convSource;
        converterTrigger |-> dmaRequest[1] || dmaRequest[3];
    endproperty
    a_convSource: assert property (p_convSource) else $error("trigger from wrong timer");
    property p_matchZero;
        $rose(matchFlags[1]) |-> timeBaseLow == 16'h0000;
    endproperty
    a_matchZero: assert property (p_matchZero) else $error("count not zero on match");
    property p_flagClear;
        $fell(matchFlags[0]) |-> $rose(s_axi_bvalid);
    endproperty
    a_flagClear: assert property (p_flagClear) else $error("flag cleared without write");

    // main scenarios reached
    c_match: cover property ($rose(matchFlags[0]));
    c_pair: cover property ($rose(matchFlags[2]));
    c_dma: cover property (dmaRequest[0]);
endmodule // timer_set_assertions

bind timer_set timer_set_assertions timer_set_assertions_i (
    .mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timeBaseLow(timeBaseLow),
    .converterTrigger(converterTrigger), .dmaRequest(dmaRequest), .matchFlags(matchFlags));

// >>> tb/ext_count_source.sv
`timescale 1ns/1ns
// ****************************************
// external count clocks and gates
// ****************************************
module ext_count_source (
    // clock
    input  wire        mclk,
    // pins toward the timers
    output logic [4:0] pinOut,
    output logic [4:0] gateOut
);
    // pins idle low until commanded
    initial begin
        pinOut = 5'h00;
        gateOut = 5'h00;
    end

    // slow edges, long enough for the pin synchronisers
    task pulses(input int idx, input int n);
        repeat (n) begin
            repeat (4) @(posedge mclk);
            pinOut[idx] <= 1'b1;
            repeat (4) @(posedge mclk);
            pinOut[idx] <= 1'b0;
        end
    endtask

    // gate level change
    task gate(input int idx, input logic v);
        @(posedge mclk);
        gateOut[idx] <= v;
    endtask
endmodule // ext_count_source

// >>> tb/timer_set_bench.sv
`timescale 1ns/1ns
// ****************************************
// timer set testbench
// ****************************************
module timer_set_bench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, converterTrigger;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [4:0]   extPins, gates, matchFlags;
    wire [15:0]  tbLow, tbHigh;
    wire [3:0]   dmaRequest;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic [1:0]  rsp;

    timer_set timer_set_i (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .extCountClockPin(extPins),
        .gatePin(gates), .timeBaseLow(tbLow), .timeBaseHigh(tbHigh), .converterTrigger(converterTrigger),
        .dmaRequest(dmaRequest), .matchFlags(matchFlags));
    ext_count_source ext_count_source_i (.mclk(mclk), .pinOut(extPins), .gateOut(gates));

    // clock and hang guard
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    // one write, address and data offered together
    task wr(input [7:0] a, input [15:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task rdReg(input [7:0] a, output [31:0] d, output [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task rc(input [7:0] a, input [31:0] e);
        rdReg(a, rd, rsp);
        chk($sformatf("reg %h", a), e, rd);
        chk("resp", 32'h0000_0000, {30'h0, rsp});
    endtask

    task waitFlag(input int k);
        int n;
        n = 0;
        while (matchFlags[k] !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk($sformatf("flag %0d", k), 32'h1, {31'h0, matchFlags[k]});
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rc(8'h00, 32'h0000_0000);
        rdReg(8'h0C, rd, rsp);
        chk("unmapped resp", 32'h2, {30'h0, rsp});
        chk("unmapped data", 32'h0, rd);
        wr(8'h00, 16'h0046);
        rc(8'h00, 32'h0000_0046);
        wr(8'h04, 16'hFFFF);
        rc(8'h04, 32'h0000_FFFF);
        // interval timer on the instruction clock
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h0000);
        wr(8'h08, 16'h0004);
        wr(8'h00, 16'h8000);
        waitFlag(0);
        wr(8'h00, 16'h0000);
        rc(8'hA0, 32'h0000_0001);
        wr(8'hA0, 16'h0001);
        rc(8'hA0, 32'h0000_0000);
        // external pin, synchronised then unsynchronised
        wr(8'h04, 16'h0000);
        wr(8'h08, 16'hFFFF);
        wr(8'h00, 16'h8006);
        ext_count_source_i.pulses(0, 3);
        repeat (8) @(posedge mclk);
        rc(8'h04, 32'h0000_0003);
        wr(8'h00, 16'h8002);
        ext_count_source_i.pulses(0, 2);
        repeat (8) @(posedge mclk);
        rc(8'h04, 32'h0000_0005);
        // gated timer on pair a low
        wr(8'h28, 16'h0005);
        wr(8'h20, 16'h8040);
        repeat (20) @(posedge mclk);
        rc(8'h24, 32'h0000_0000);
        ext_count_source_i.gate(1, 1'b1);
        waitFlag(1);
        ext_count_source_i.gate(1, 1'b0);
        repeat (4) @(posedge mclk);
        rc(8'h24, 32'h0000_0004);
        rc(8'h24, 32'h0000_0004);
        wr(8'h20, 16'h0000);
        wr(8'hA0, 16'h001F);
        // joined pair a, high control would gate if honoured
        wr(8'h24, 16'hFFF0);
        wr(8'h44, 16'h0000);
        wr(8'h28, 16'h0002);
        wr(8'h48, 16'h0001);
        wr(8'h40, 16'h8040);
        wr(8'h20, 16'h8008);
        waitFlag(2);
        chk("low flag", 32'h0, {31'h0, matchFlags[1]});
        wr(8'h20, 16'h0000);
        // time base copies of pair a counts while both stand still
        wr(8'h44, 16'h1234);
        wr(8'h24, 16'h0ABC);
        repeat (2) @(posedge mclk);
        chk("time base low", 32'h0000_0ABC, {16'h0000, tbLow});
        chk("time base high", 32'h0000_1234, {16'h0000, tbHigh});
        end_of_test();
    end
endmodule // timer_set_bench
